// ===== dfs_pkg.sv
// package of constants and types for the data array program/erase sequencer
package dfs_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] DFS_OFS_STATUS    = 8'h00; // command_status_register
  localparam logic [7:0] DFS_OFS_CONFIG    = 8'h04; // command_config_register
  localparam logic [7:0] DFS_OFS_ERR_CFG   = 8'h08; // error_config_register
  localparam logic [7:0] DFS_OFS_ERR_STAT  = 8'h0c; // error_status_register
  localparam logic [7:0] DFS_OFS_INDEX     = 8'h10; // command_index
  localparam logic [7:0] DFS_OFS_PARAM     = 8'h14; // command_parameter at the current index
  localparam logic [7:0] DFS_OFS_SECURITY  = 8'h18; // security_register
  localparam logic [7:0] DFS_OFS_PROTECT   = 8'h1c; // protection boundary
  localparam logic [7:0] DFS_OFS_MODE      = 8'h20; // operating mode control

  // status register bit positions
  localparam int DFS_ST_COMMAND_COMPLETE_FLAG   = 7;
  localparam int DFS_ST_ACCESS_ERROR_FLAG = 5;
  localparam int DFS_ST_PVIOL  = 4;
  localparam int DFS_ST_MG1    = 1;
  localparam int DFS_ST_MG0    = 0;

  // error config / status bit positions
  localparam int DFS_EF_DOUBLE = 1;
  localparam int DFS_EF_SINGLE = 0;

  // command codes and parameter slots
  localparam logic [7:0] DFS_CMD_PROGRAM = 8'h11;
  localparam logic [7:0] DFS_CMD_ERASE   = 8'h12;
  localparam logic [2:0] DFS_IX_ADDR     = 3'h1;
  localparam logic [2:0] DFS_IX_WORD0    = 3'h2;
  localparam logic [2:0] DFS_IX_WORD3    = 3'h5;
  localparam int         DFS_SLOTS       = 6;

  // data array geometry, global byte addresses
  localparam logic [22:0] DFS_ARRAY_BASE  = 23'h10_0000;
  localparam logic [22:0] DFS_ARRAY_LIMIT = 23'h10_8000;
  localparam int          DFS_SECTOR_LSB  = 8;
  localparam logic [22:0] DFS_SECURITY_ADDR = 23'h7f_ff0f;

  // operation timing
  localparam int DFS_PROG_NS        = 1000;
  localparam int DFS_ERASE_NS       = 20000;
  localparam int DFS_CLK_NS         = 10;
  localparam int DFS_PROG_CYC       = (DFS_PROG_NS + DFS_CLK_NS - 1) / DFS_CLK_NS;
  localparam int DFS_ERASE_CYC      = (DFS_ERASE_NS + DFS_CLK_NS - 1) / DFS_CLK_NS;
  localparam int DFS_CNT_W          = 16;

  // security byte field and reset fallback
  localparam logic [7:0] DFS_SEC_DEFAULT = 8'hff;
  localparam logic [1:0] DFS_SEC_UNSECURE = 2'h2;

  typedef enum logic [6:0] {
    DFS_BOOT    = 7'b0000001,
    DFS_BOOTRD  = 7'b0000010,
    DFS_IDLE    = 7'b0000100,
    DFS_CHECK   = 7'b0001000,
    DFS_PROGRAM = 7'b0010000,
    DFS_ERASE   = 7'b0100000,
    DFS_VERIFY  = 7'b1000000
  } dfs_state_t;

endpackage : dfs_pkg

// ===== dfs_array_if.sv
// interface between the sequencer and the array access module
`timescale 1ns/100ps
`default_nettype none
interface dfs_array_if;
  logic        rd_en;
  logic        wr_en;
  logic        erase_en;
  logic [22:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ecc_single;
  logic        ecc_double;

  modport seq (output rd_en, output wr_en, output erase_en, output addr, output wdata,
               input rdata, input ecc_single, input ecc_double);
  modport mem (input rd_en, input wr_en, input erase_en, input addr, input wdata,
               output rdata, output ecc_single, output ecc_double);
endinterface : dfs_array_if
`default_nettype wire

// ===== dfs_array_port.sv
// array access port: registers the external array strobes and read data
`timescale 1ns/100ps
`default_nettype none
module dfs_array_port
  import dfs_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  dfs_array_if.mem         arr,
  output logic             o_rd,
  output logic             o_wr,
  output logic             o_erase,
  output logic [22:0]      o_addr,
  output logic [15:0]      o_wdata,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_ecc_single,
  input  wire logic        i_ecc_double
);

  // strobes leave through flip-flops, read data return through one stage
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd    <= 1'b0;
      o_wr    <= 1'b0;
      o_erase <= 1'b0;
      o_addr  <= '0;
      o_wdata <= '0;
    end else begin
      o_rd    <= arr.rd_en;
      o_wr    <= arr.wr_en;
      o_erase <= arr.erase_en;
      o_addr  <= arr.addr;
      o_wdata <= arr.wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arr.rdata      <= '0;
      arr.ecc_single <= 1'b0;
      arr.ecc_double <= 1'b0;
    end else begin
      arr.rdata      <= i_rdata;
      arr.ecc_single <= i_ecc_single;
      arr.ecc_double <= i_ecc_double;
    end
  end

endmodule : dfs_array_port
`default_nettype wire

// ===== dfs_sequencer.sv
// data array program/erase sequencer with apb register slave
// What this block does
// - program-words writes one to four erased words, then verifies each one
// - program slots: code 0x11 plus address high, address low, words zero to three
// - command index at launch sets how many words are programmed
// - clearing the completion flag launches; program only if unprotected; flag sets when done
// - program launch with index below 010 or above 101 raises access error
// - program: invalid address, odd address or run past array end is access error
// - command not allowed in current mode and security state raises access error
// - protected target raises protection violation and leaves array untouched
// - verify pass sets fault-any on any error, fault-uncorrectable on double errors
// - erase slots: code 0x12 plus address high, address anywhere in sector
// - erase clears whole sector, verifies its base word only, then sets completion flag
// - erase launch with index not 001, invalid or odd address is access error
// - command interrupt is completion flag and its enable
// - error interrupt is double or single fault flag with its enable
// - wait mode changes nothing; command interrupt can wake from wait
// - stop request while busy is held off until command completes
// - security register loads from the security byte at reset
// - newly programmed security byte only acts after next reset
// - index and parameter writes ignored while reset sequence is busy
// - reset during a command aborts it at once
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module dfs_sequencer
  import dfs_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_stop_req,
  output logic             o_stop_ack,
  output logic             o_cmd_irq,
  output logic             o_err_irq,
  output logic [1:0]       o_security_state,
  output logic             o_arr_rd,
  output logic             o_arr_wr,
  output logic             o_arr_erase,
  output logic [22:0]      o_arr_addr,
  output logic [15:0]      o_arr_wdata,
  input  wire logic [15:0] i_arr_rdata,
  input  wire logic        i_arr_ecc_single,
  input  wire logic        i_arr_ecc_double
);

  dfs_array_if arr ();

  dfs_array_port u_port (
    .i_sys_clk    (i_sys_clk),
    .i_rst_b      (i_rst_b),
    .arr          (arr),
    .o_rd         (o_arr_rd),
    .o_wr         (o_arr_wr),
    .o_erase      (o_arr_erase),
    .o_addr       (o_arr_addr),
    .o_wdata      (o_arr_wdata),
    .i_rdata      (i_arr_rdata),
    .i_ecc_single (i_arr_ecc_single),
    .i_ecc_double (i_arr_ecc_double)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  dfs_state_t            state;
  logic                  command_complete_flag;
  logic                  access_error_flag;
  logic                  protection_violation_flag;
  logic                  verify_fault_any;
  logic                  verify_fault_uncorrectable;
  logic                  command_complete_irq_enable;
  logic                  double_bit_fault_irq_enable;
  logic                  single_bit_fault_irq_enable;
  logic                  double_bit_fault_flag;
  logic                  single_bit_fault_flag;
  logic [2:0]            command_index;
  logic [15:0]           command_parameter [DFS_SLOTS];
  logic [7:0]            security_register;
  logic [22:0]           protect_base;
  logic                  special_mode;
  logic [2:0]            launch_index;
  logic [1:0]            word_cnt;
  logic [1:0]            word_last;
  logic [22:0]           op_addr;
  logic [DFS_CNT_W-1:0]  wait_cnt;
  logic                  rd_pending;
  logic                  rd_seen;
  logic                  rd_mid;

  logic                  wr_acc;
  logic                  rd_acc;
  logic                  launch;
  logic                  regs_open;
  logic [7:0]            cmd_code;
  logic [22:0]           cmd_addr;
  logic                  addr_ok;
  logic                  allowed;
  logic                  is_prog;
  logic                  is_erase;
  logic                  launch_err;
  logic                  launch_prot;
  logic [22:0]           sector_base;
  logic [22:0]           last_addr;
  logic                  verify_last;

  assign wr_acc    = psel && penable && pwrite;
  assign rd_acc    = psel && penable && !pwrite;
  assign pready    = 1'b1;
  assign regs_open = command_complete_flag && (state == DFS_IDLE);
  // writing one to the flag bit clears it and launches
  assign launch    = wr_acc && (paddr == DFS_OFS_STATUS) && pwdata[DFS_ST_COMMAND_COMPLETE_FLAG] && regs_open;

  ////////////////////////////////////////////////////////////////////////////
  // launch checks

  assign cmd_code    = command_parameter[0][15:8];
  assign cmd_addr    = {command_parameter[0][6:0], command_parameter[DFS_IX_ADDR]};
  assign is_prog     = (cmd_code == DFS_CMD_PROGRAM);
  assign is_erase    = (cmd_code == DFS_CMD_ERASE);
  assign last_addr   = cmd_addr + {20'h0, 2'(command_index - DFS_IX_WORD0), 1'b0};
  assign addr_ok     = (cmd_addr >= DFS_ARRAY_BASE) && (cmd_addr < DFS_ARRAY_LIMIT) && !cmd_addr[0];
  // unsecured or special mode may modify the array
  assign allowed     = special_mode || (security_register[1:0] == DFS_SEC_UNSECURE);
  assign sector_base = {cmd_addr[22:DFS_SECTOR_LSB], {DFS_SECTOR_LSB{1'b0}}};

  always_comb begin
    launch_err = 1'b0;
    if (!allowed || !(is_prog || is_erase)) begin
      launch_err = 1'b1;
    end else if (is_prog) begin
      if (command_index < DFS_IX_WORD0 || command_index > DFS_IX_WORD3) begin
        launch_err = 1'b1;
      end else if (!addr_ok || last_addr >= DFS_ARRAY_LIMIT) begin
        launch_err = 1'b1;
      end
    end else if (command_index != DFS_IX_ADDR || !addr_ok) begin
      launch_err = 1'b1;
    end
  end

  // area at or above the boundary is protected
  assign launch_prot = is_prog ? (last_addr >= protect_base)
                               : (sector_base >= protect_base || sector_base + 23'h100 > protect_base);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign verify_last = rd_seen && (word_cnt == word_last);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state                 <= DFS_BOOT;
      command_complete_flag <= 1'b0;
      launch_index          <= '0;
      word_cnt              <= '0;
      word_last             <= '0;
      op_addr               <= '0;
      wait_cnt              <= '0;
      rd_pending            <= 1'b0;
      rd_mid                <= 1'b0;
      rd_seen               <= 1'b0;
    end else begin
      // strobe stage, array answer, then the port's capture stage
      rd_pending <= arr.rd_en;
      rd_mid     <= rd_pending;
      rd_seen    <= rd_mid;
      case (state)
        DFS_BOOT: begin
          state <= DFS_BOOTRD;
        end
        DFS_BOOTRD: begin
          if (rd_seen) begin
            state                 <= DFS_IDLE;
            command_complete_flag <= 1'b1;
          end
        end
        DFS_IDLE: begin
          if (launch) begin
            command_complete_flag <= 1'b0;
            launch_index          <= command_index;
            state                 <= DFS_CHECK;
          end
        end
        DFS_CHECK: begin
          if (launch_err || launch_prot) begin
            command_complete_flag <= 1'b1;
            state                 <= DFS_IDLE;
          end else if (is_prog) begin
            word_cnt  <= '0;
            word_last <= 2'(launch_index - DFS_IX_WORD0);
            op_addr   <= cmd_addr;
            wait_cnt  <= DFS_CNT_W'(DFS_PROG_CYC);
            state     <= DFS_PROGRAM;
          end else begin
            word_cnt  <= '0;
            word_last <= '0;
            op_addr   <= sector_base;
            wait_cnt  <= DFS_CNT_W'(DFS_ERASE_CYC);
            state     <= DFS_ERASE;
          end
        end
        DFS_PROGRAM: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else if (word_cnt == word_last) begin
            word_cnt <= '0;
            op_addr  <= cmd_addr;
            state    <= DFS_VERIFY;
          end else begin
            word_cnt <= word_cnt + 1'b1;
            op_addr  <= op_addr + 23'h2;
            wait_cnt <= DFS_CNT_W'(DFS_PROG_CYC);
          end
        end
        DFS_ERASE: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else begin
            word_last <= 2'(launch_index - launch_index);
            state     <= DFS_VERIFY;
          end
        end
        DFS_VERIFY: begin
          // erase verify samples the sector base only; a full sweep costs too much here
          if (verify_last) begin
            command_complete_flag <= 1'b1;
            state                 <= DFS_IDLE;
          end else if (rd_seen) begin
            word_cnt <= word_cnt + 1'b1;
            op_addr  <= op_addr + 23'h2;
          end
        end
        default: begin
          state <= DFS_BOOT;
        end
      endcase
    end
  end

  // array strobes: write only from the program state so a protected area stays untouched
  assign arr.wr_en    = (state == DFS_PROGRAM) && (wait_cnt == DFS_CNT_W'(DFS_PROG_CYC));
  assign arr.erase_en = (state == DFS_ERASE) && (wait_cnt == DFS_CNT_W'(DFS_ERASE_CYC));
  assign arr.rd_en    = ((state == DFS_BOOT) || (state == DFS_VERIFY)) && !rd_pending && !rd_mid && !rd_seen;
  assign arr.addr     = (state == DFS_BOOT) ? DFS_SECURITY_ADDR : op_addr;
  assign arr.wdata    = command_parameter[3'(DFS_IX_WORD0) + 3'(word_cnt)];

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
    end else if (state == DFS_CHECK) begin
      access_error_flag         <= launch_err;
      protection_violation_flag <= !launch_err && launch_prot;
    end else if (wr_acc && paddr == DFS_OFS_STATUS) begin
      if (pwdata[DFS_ST_ACCESS_ERROR_FLAG]) access_error_flag <= 1'b0;
      if (pwdata[DFS_ST_PVIOL]) protection_violation_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      verify_fault_any           <= 1'b0;
      verify_fault_uncorrectable <= 1'b0;
    end else if (launch) begin
      verify_fault_any           <= 1'b0;
      verify_fault_uncorrectable <= 1'b0;
    end else if (rd_seen && (state == DFS_VERIFY || state == DFS_BOOTRD)) begin
      if (arr.ecc_single || arr.ecc_double) verify_fault_any <= 1'b1;
      if (arr.ecc_double) verify_fault_uncorrectable <= 1'b1;
      if (state == DFS_VERIFY && state != DFS_BOOTRD && launch_index == DFS_IX_ADDR
          && arr.rdata != 16'hffff) verify_fault_any <= 1'b1;
      if (state == DFS_VERIFY && launch_index != DFS_IX_ADDR && arr.rdata != arr.wdata) verify_fault_any <= 1'b1;
    end
  end

  // ecc read fault flags: write one to clear, a new fault in the same cycle wins
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      double_bit_fault_flag <= 1'b0;
      single_bit_fault_flag <= 1'b0;
    end else begin
      double_bit_fault_flag <= (rd_seen && arr.ecc_double) ||
        (double_bit_fault_flag && !(wr_acc && paddr == DFS_OFS_ERR_STAT && pwdata[DFS_EF_DOUBLE]));
      single_bit_fault_flag <= (rd_seen && arr.ecc_single && !arr.ecc_double) ||
        (single_bit_fault_flag && !(wr_acc && paddr == DFS_OFS_ERR_STAT && pwdata[DFS_EF_SINGLE]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      command_complete_irq_enable <= 1'b0;
      double_bit_fault_irq_enable <= 1'b0;
      single_bit_fault_irq_enable <= 1'b0;
      protect_base                <= DFS_ARRAY_LIMIT;
      special_mode                <= 1'b0;
    end else if (wr_acc) begin
      case (paddr)
        DFS_OFS_CONFIG: command_complete_irq_enable <= pwdata[DFS_ST_COMMAND_COMPLETE_FLAG];
        DFS_OFS_ERR_CFG: begin
          double_bit_fault_irq_enable <= pwdata[DFS_EF_DOUBLE];
          single_bit_fault_irq_enable <= pwdata[DFS_EF_SINGLE];
        end
        DFS_OFS_PROTECT: protect_base <= pwdata[22:0];
        DFS_OFS_MODE: special_mode <= pwdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      command_index <= '0;
    end else if (wr_acc && paddr == DFS_OFS_INDEX && regs_open) begin
      command_index <= pwdata[2:0];
    end
  end

  for (genvar g = 0; g < DFS_SLOTS; g++) begin : g_param
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        command_parameter[g] <= '0;
      end else if (wr_acc && paddr == DFS_OFS_PARAM && regs_open && command_index == 3'(g)) begin
        command_parameter[g] <= pwdata[15:0];
      end
    end
  end

  // security byte is sampled only by the reset read; later programming waits for next reset
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      security_register <= DFS_SEC_DEFAULT;
    end else if (state == DFS_BOOTRD && rd_seen) begin
      security_register <= arr.ecc_double ? DFS_SEC_DEFAULT : arr.rdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and outputs

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          DFS_OFS_STATUS: begin
            prdata[DFS_ST_COMMAND_COMPLETE_FLAG]   <= command_complete_flag;
            prdata[DFS_ST_ACCESS_ERROR_FLAG] <= access_error_flag;
            prdata[DFS_ST_PVIOL]  <= protection_violation_flag;
            prdata[DFS_ST_MG1]    <= verify_fault_any;
            prdata[DFS_ST_MG0]    <= verify_fault_uncorrectable;
          end
          DFS_OFS_CONFIG:   prdata[DFS_ST_COMMAND_COMPLETE_FLAG] <= command_complete_irq_enable;
          DFS_OFS_ERR_CFG:  prdata[1:0] <= {double_bit_fault_irq_enable, single_bit_fault_irq_enable};
          DFS_OFS_ERR_STAT: prdata[1:0] <= {double_bit_fault_flag, single_bit_fault_flag};
          DFS_OFS_INDEX:    prdata[2:0] <= command_index;
          DFS_OFS_PARAM:    prdata[15:0] <= (command_index < 3'(DFS_SLOTS)) ?
                                            command_parameter[command_index] : 16'h0000;
          DFS_OFS_SECURITY: prdata[7:0] <= security_register;
          DFS_OFS_PROTECT:  prdata[22:0] <= protect_base;
          DFS_OFS_MODE:     prdata[0] <= special_mode;
          default:          pslverr <= 1'b1;
        endcase
      end else if (psel && !penable && pwrite) begin
        pslverr <= !(paddr inside {DFS_OFS_STATUS, DFS_OFS_CONFIG, DFS_OFS_ERR_CFG, DFS_OFS_ERR_STAT,
                                   DFS_OFS_INDEX, DFS_OFS_PARAM, DFS_OFS_SECURITY, DFS_OFS_PROTECT,
                                   DFS_OFS_MODE});
      end
    end
  end

  // wait mode has no input here: the block runs on unchanged and the irq wakes the core
  assign o_cmd_irq        = command_complete_flag && command_complete_irq_enable;
  assign o_err_irq        = (double_bit_fault_flag && double_bit_fault_irq_enable) ||
                            (single_bit_fault_flag && single_bit_fault_irq_enable);
  assign o_stop_ack       = i_stop_req && command_complete_flag;
  assign o_security_state = security_register[1:0];

endmodule : dfs_sequencer
`default_nettype wire

// ===== dfs_properties.sv
// port-level assertions for the data array sequencer
`timescale 1ns/100ps
`default_nettype none
module dfs_properties
  import dfs_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_stop_req,
  input wire logic        o_stop_ack,
  input wire logic        o_cmd_irq,
  input wire logic [1:0]  o_security_state,
  input wire logic        o_arr_rd,
  input wire logic        o_arr_wr,
  input wire logic        o_arr_erase,
  input wire logic [22:0] o_arr_addr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic [4:0] cyc;
  // the security load is long over before this saturates
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      cyc <= 5'h00;
    else if (cyc != 5'h1f)
      cyc <= cyc + 5'h01;
  end
  a_ack_needs_req: assert property (o_stop_ack |-> i_stop_req) else $error("stop ack unasked");
  a_irq_grants_stop: assert property (i_stop_req && o_cmd_irq |-> o_stop_ack) else $error("stop held");
  a_busy_holds_stop: assert property (o_arr_wr || o_arr_erase |-> !o_stop_ack && !o_cmd_irq) else $error("busy");
  a_word_in_array: assert property (o_arr_wr |-> !o_arr_addr[0] && o_arr_addr >= DFS_ARRAY_BASE
    && o_arr_addr < DFS_ARRAY_LIMIT) else $error("bad word address");
  a_erase_in_array: assert property (o_arr_erase |-> o_arr_addr >= DFS_ARRAY_BASE
    && o_arr_addr < DFS_ARRAY_LIMIT) else $error("bad sector");
  a_word_spacing: assert property (o_arr_wr |=> !o_arr_wr [*8]) else $error("words too close");
  logic [11:0] erase_age;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      erase_age <= 12'h000;
    else if (o_arr_erase || o_arr_rd)
      erase_age <= {11'h000, o_arr_erase};
    else if (erase_age != 12'h000)
      erase_age <= erase_age + 12'h001;
  end
  a_erase_then_verify: assert property (erase_age <= 12'(DFS_ERASE_CYC + 16)) else $error("no verify");
  a_security_frozen: assert property (cyc == 5'h1f |-> $stable(o_security_state)) else $error("sec moved");
  c_erase: cover property (o_arr_erase);
  c_word: cover property (o_arr_wr);
  c_stop: cover property (o_stop_ack);
endmodule // dfs_properties
bind dfs_sequencer dfs_properties u_props (.i_sys_clk, .i_rst_b, .i_stop_req, .o_stop_ack, .o_cmd_irq,
  .o_security_state, .o_arr_rd, .o_arr_wr, .o_arr_erase, .o_arr_addr);
`default_nettype wire

// ===== tb.sv
// self-checking bench for the data array sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dfs_pkg::*;
  localparam logic [22:0] base = DFS_ARRAY_BASE;
  logic        i_sys_clk = 1'b0, i_rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        i_stop_req = 1'b0, ecc_d = 1'b0, i_arr_ecc_double = 1'b0, ecc_s = 1'b0, i_arr_ecc_single = 1'b0;
  logic        pready, pslverr, o_stop_ack, o_cmd_irq, o_err_irq, o_arr_rd, o_arr_wr, o_arr_erase;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, s;
  logic [1:0]  o_security_state;
  logic [22:0] o_arr_addr;
  logic [15:0] o_arr_wdata, i_arr_rdata = 16'h0, sec_w = 16'hfefe, mem [logic [22:0]];
  int          err_count = 0, num_checks = 0, nwr = 0, ner = 0, n0;
  dfs_sequencer u_dut (.i_sys_clk, .i_rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .i_stop_req, .o_stop_ack, .o_cmd_irq, .o_err_irq, .o_security_state, .o_arr_rd, .o_arr_wr,
    .o_arr_erase, .o_arr_addr, .o_arr_wdata, .i_arr_rdata, .i_arr_ecc_single, .i_arr_ecc_double);
  always #5 i_sys_clk = ~i_sys_clk;
  // array stand-in: answer lands the cycle after the strobe, erased words read all ones
  always @(posedge i_sys_clk) begin
    i_arr_rdata <= (o_arr_addr == DFS_SECURITY_ADDR) ? sec_w
                 : (mem.exists(o_arr_addr) ? mem[o_arr_addr] : 16'hffff);
    i_arr_ecc_double <= o_arr_rd & ecc_d;
    i_arr_ecc_single <= o_arr_rd & ecc_s;
    if (o_arr_wr) begin
      mem[o_arr_addr] = o_arr_wdata;
      nwr++;
    end
    if (o_arr_erase) begin
      mem.delete();
      ner++;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do @(posedge i_sys_clk); while (pready !== 1'b1);
    if (!w) s = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done();
    s = 32'h0;
    for (int i = 0; i < 2000 && s[DFS_ST_COMMAND_COMPLETE_FLAG] !== 1'b1; i++) apb(1'b0, DFS_OFS_STATUS, 32'h0);
    chk(s[DFS_ST_COMMAND_COMPLETE_FLAG], 1'b1);
  endtask
  // loads every slot, then leaves the index at ix for the launch
  task automatic cmd(input logic [7:0] code, input logic [22:0] a, input logic [2:0] ix);
    apb(1'b1, DFS_OFS_STATUS, 32'h30);
    apb(1'b1, DFS_OFS_INDEX, 32'h0);
    apb(1'b1, DFS_OFS_PARAM, {16'h0, code, 1'b0, a[22:16]});
    apb(1'b1, DFS_OFS_INDEX, 32'h1);
    apb(1'b1, DFS_OFS_PARAM, {16'h0, a[15:0]});
    for (int i = 2; i < 6; i++) begin
      apb(1'b1, DFS_OFS_INDEX, i);
      apb(1'b1, DFS_OFS_PARAM, 32'ha500 + i);
    end
    apb(1'b1, DFS_OFS_INDEX, {29'h0, ix});
    apb(1'b1, DFS_OFS_STATUS, 32'h80);
    wait_done();
  endtask
  task automatic t_index();
    for (int ix = 0; ix < 8; ix++) begin
      n0 = nwr;
      cmd(DFS_CMD_PROGRAM, base + 23'(ix * 16), 3'(ix));
      chk(s & 32'hb3, (ix > 1 && ix < 6) ? 32'h80 : 32'ha0);
      chk(nwr - n0, (ix > 1 && ix < 6) ? ix - 1 : 0);
      chk(o_cmd_irq, 1'b1);
    end
    chk(mem[base + 23'h56], 16'ha505);
    $display("index test done");
  endtask
  task automatic t_bad();
    logic [22:0] bad [3] = '{base + 23'h101, DFS_ARRAY_LIMIT - 23'h2, base - 23'h2};
    n0 = nwr;
    apb(1'b1, DFS_OFS_PROTECT, 32'(base) + 32'h100);
    cmd(DFS_CMD_PROGRAM, base + 23'h100, 3'h2);
    chk(s & 32'hb3, 32'h90);
    apb(1'b1, DFS_OFS_PROTECT, 32'(DFS_ARRAY_LIMIT));
    for (int i = 0; i < 3; i++) begin
      cmd(DFS_CMD_PROGRAM, bad[i], 3'h3);
      chk(s & 32'hb3, 32'ha0);
    end
    chk(nwr, n0);
    $display("address test done");
  endtask
  task automatic t_erase();
    cmd(DFS_CMD_ERASE, base + 23'h12, 3'h2);
    chk(s & 32'hb3, 32'ha0);
    apb(1'b1, DFS_OFS_ERR_CFG, 32'h2);
    ecc_d <= 1'b1;
    i_stop_req <= 1'b1;
    n0 = ner;
    cmd(DFS_CMD_ERASE, base + 23'h12, 3'h1);
    chk(s & 32'hb3, 32'h83);
    chk(ner - n0, 1);
    chk({o_stop_ack, o_err_irq}, 2'b11);
    ecc_d <= 1'b0;
    i_stop_req <= 1'b0;
    apb(1'b1, DFS_OFS_ERR_STAT, 32'h3);
    #1;
    chk(o_err_irq, 1'b0);
    $display("erase test done");
  endtask
  task automatic t_secure();
    @(posedge i_sys_clk);
    sec_w <= 16'hffff;
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    wait_done();
    chk(o_security_state, 2'b11);
    n0 = nwr;
    cmd(DFS_CMD_PROGRAM, base + 23'h200, 3'h2);
    chk(s & 32'hb3, 32'ha0);
    apb(1'b1, DFS_OFS_MODE, 32'h1);
    ecc_s <= 1'b1;
    cmd(DFS_CMD_PROGRAM, base + 23'h200, 3'h2);
    chk({s[23:0] & 24'hb3, 8'(nwr - n0)}, 32'h8201);
    $display("security test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    wait_done();
    chk(o_security_state, 2'b10);
    apb(1'b1, DFS_OFS_CONFIG, 32'h80);
    t_index();
    t_bad();
    t_erase();
    t_secure();
    end_sim();
  end
  initial begin
    #1000000;
    err_count++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
